// [src/waveform_steer.sv]
// Top of the waveform steering block: APB registers, input select, shutdown.
// Assumes all sources are synchronous to sys_clk; the fast oscillator comes
// in as a one-cycle tick pulse.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module waveform_steer
    import waveform_steer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_derived_input,
    input wire logic [1:0] ccp_out,
    input wire logic [3:0] pwm_out,
    input wire logic nco_out,
    input wire logic [1:0] comparator_out,
    input wire logic [3:0] logic_cell_out,
    input wire logic timer_postscale_out,
    input wire logic mapped_input_pin_select,
    input wire logic internal_fast_oscillator,
    output logic gen_clock_select,
    output logic [3:0] output_level,
    output logic [3:0] output_enable,
    output logic irq
);
    logic [7:0] con0_reg;
    logic [3:0] pol_reg;
    logic [5:0] dbr_reg;
    logic [5:0] dbf_reg;
    logic [6:0] as0_reg;
    logic shutdown_reg, shutdown_next;
    logic shut_prev_reg;
    logic [4:0] as1_reg;
    logic [7:0] str_reg;
    logic clk_sel_reg;
    logic [3:0] dat_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_en_reg;
    logic [31:0] prdata_reg;
    logic wave_reg, wave_prev_reg;
    logic wave_sel;
    logic wave_rise, wave_edge;
    logic [4:0] sources;
    logic request;
    logic setup, wr_en;
    logic [7:0] wbyte;
    logic [1:0] events;
    logic [7:0] as0_merged;

    steer_if bus ();

    // Merges the write byte into a register under its writable mask.
    function automatic logic [7:0] merge(input logic [7:0] old,
        input logic [7:0] data, input logic [7:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction

    // Word offsets that answer without an error.
    function automatic logic mapped(input logic [7:0] addr);
        case (addr)
            OFS_CON0, OFS_CON1, OFS_DBR, OFS_DBF, OFS_AS0, OFS_AS1,
            OFS_STR, OFS_CLK, OFS_DAT, OFS_IRQ_STAT, OFS_IRQ_CLR,
            OFS_IRQ_EN: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // Zero wait states; unmapped offsets answer with an error.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pstrb[0] && mapped(paddr);
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = prdata_reg;

    // Read data is captured in the setup cycle and stands in the access phase.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0;
        end else if (setup && !pwrite) begin
            case (paddr)
                OFS_CON0: prdata_reg <= {24'h0, con0_reg};
                OFS_CON1: prdata_reg <= {26'h0, wave_reg, 1'b0, pol_reg};
                OFS_DBR: prdata_reg <= {26'h0, dbr_reg};
                OFS_DBF: prdata_reg <= {26'h0, dbf_reg};
                OFS_AS0: prdata_reg <= {24'h0, shutdown_reg, as0_reg};
                OFS_AS1: prdata_reg <= {27'h0, as1_reg};
                OFS_STR: prdata_reg <= {24'h0, str_reg};
                OFS_CLK: prdata_reg <= {31'h0, clk_sel_reg};
                OFS_DAT: prdata_reg <= {28'h0, dat_reg};
                OFS_IRQ_STAT: prdata_reg <= {30'h0, irq_stat_reg};
                OFS_IRQ_EN: prdata_reg <= {30'h0, irq_en_reg};
                default: prdata_reg <= 32'h0;
            endcase
        end
    end

    // Enable and mode; the load bit sets only once the module is enabled
    // and clears on the next input edge, a write that sets it winning.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            con0_reg <= REG_RESET;
        end else if (wr_en && paddr == OFS_CON0) begin
            con0_reg <= merge(con0_reg, wbyte, CON0_MASK);
            con0_reg[CON0_LD] <= wbyte[CON0_LD] && con0_reg[CON0_EN];
        end else if (wave_edge) begin
            con0_reg[CON0_LD] <= 1'b0;
        end
    end

    // Polarity and dead-band values.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pol_reg <= 4'h0;
            dbr_reg <= 6'h0;
            dbf_reg <= 6'h0;
        end else if (wr_en) begin
            if (paddr == OFS_CON1) begin
                pol_reg <= wbyte[3:0] & POL_MASK[3:0];
            end
            if (paddr == OFS_DBR) begin
                dbr_reg <= wbyte[5:0] & DB_MASK[5:0];
            end
            if (paddr == OFS_DBF) begin
                dbf_reg <= wbyte[5:0] & DB_MASK[5:0];
            end
        end
    end

    // Shutdown control, source enables, steering, clock and input select.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            as0_reg <= AS0_RESET[6:0];
            as1_reg <= REG_RESET[4:0];
            str_reg <= REG_RESET;
            clk_sel_reg <= 1'b0; // [R10]
            dat_reg <= REG_RESET[3:0];
        end else if (wr_en) begin
            if (paddr == OFS_AS0) begin
                as0_reg <= as0_merged[6:0];
            end
            if (paddr == OFS_AS1) begin
                as1_reg <= wbyte[4:0] & AS1_MASK[4:0];
            end
            if (paddr == OFS_STR) begin
                str_reg <= wbyte;
            end
            if (paddr == OFS_CLK) begin
                clk_sel_reg <= wbyte[0] & CLK_MASK[0];
            end
            if (paddr == OFS_DAT) begin
                dat_reg <= wbyte[3:0] & DAT_MASK[3:0];
            end
        end
    end

    // Shutdown control word with the write merged under its mask.
    assign as0_merged = merge({1'b0, as0_reg}, wbyte, AS0_MASK);

    // Input waveform select; reserved codes connect nothing.
    always_comb begin
        case (dat_reg)
            4'h0: wave_sel = clock_derived_input; // [R11]
            4'h1: wave_sel = ccp_out[0];
            4'h2: wave_sel = ccp_out[1];
            4'h3: wave_sel = pwm_out[0];
            4'h4: wave_sel = pwm_out[1];
            4'h5: wave_sel = pwm_out[2];
            4'h6: wave_sel = pwm_out[3];
            4'h7: wave_sel = nco_out;
            4'h8: wave_sel = comparator_out[0]; // [R12]
            4'h9: wave_sel = comparator_out[1];
            4'hA: wave_sel = logic_cell_out[0];
            4'hB: wave_sel = logic_cell_out[1];
            4'hC: wave_sel = logic_cell_out[2];
            4'hD: wave_sel = logic_cell_out[3];
            default: wave_sel = 1'b0; // [R13]
        endcase
    end

    // Sampled input waveform and its edges.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wave_reg <= 1'b0;
            wave_prev_reg <= 1'b0;
        end else begin
            wave_reg <= wave_sel;
            wave_prev_reg <= wave_reg;
        end
    end

    assign wave_rise = wave_reg && !wave_prev_reg;
    assign wave_edge = wave_reg != wave_prev_reg;

    // Each source counts only while its enable bit is set.
    assign sources[SRC_LC2] = logic_cell_out[1] && as1_reg[SRC_LC2]; // [R1]
    assign sources[SRC_CMP2] = comparator_out[1] && as1_reg[SRC_CMP2]; // [R2]
    assign sources[SRC_CMP1] = comparator_out[0] && as1_reg[SRC_CMP1]; // [R3]
    assign sources[SRC_TMR] = timer_postscale_out && as1_reg[SRC_TMR]; // [R4]
    assign sources[SRC_PIN] =
        mapped_input_pin_select && as1_reg[SRC_PIN]; // [R5]
    assign request = |sources; // [R17]

    // Shutdown flag: hardware set beats a software clear; auto-restart
    // clears it once no enabled source is high.
    always_comb begin
        shutdown_next = shutdown_reg;
        if (request) begin
            shutdown_next = 1'b1; // [R17]
        end else if (wr_en && paddr == OFS_AS0) begin
            shutdown_next = wbyte[AS0_SHUT];
        end else if (as0_reg[AS0_REN]) begin
            shutdown_next = 1'b0; // [R16]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shutdown_reg <= 1'b0;
            shut_prev_reg <= 1'b0;
        end else begin
            shutdown_reg <= shutdown_next;
            shut_prev_reg <= shutdown_reg;
        end
    end

    // One-cycle event pulses: shutdown entered and shutdown left.
    assign events[IRQ_ENTER] = shutdown_reg && !shut_prev_reg;
    assign events[IRQ_LEAVE] = !shutdown_reg && shut_prev_reg;

    // Write-one-to-clear status; a new event in the clear cycle survives.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_stat_reg <= 2'h0;
            irq_en_reg <= 2'h0;
        end else begin
            if (wr_en && paddr == OFS_IRQ_CLR) begin
                irq_stat_reg <= (irq_stat_reg & ~wbyte[1:0]) | events;
            end else begin
                irq_stat_reg <= irq_stat_reg | events;
            end
            if (wr_en && paddr == OFS_IRQ_EN) begin
                irq_en_reg <= wbyte[1:0] & IRQ_MASK[1:0];
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    // The generator clock is the system clock or the fast oscillator tick.
    assign gen_clock_select = clk_sel_reg;
    assign bus.gen_tick =
        clk_sel_reg ? internal_fast_oscillator : 1'b1; // [R10]
    assign bus.wave = wave_reg;
    assign bus.wave_rise = wave_rise;
    assign bus.enable = con0_reg[CON0_EN];
    assign bus.mode = con0_reg[2:0];
    assign bus.pol = pol_reg;
    assign bus.str = str_reg[3:0];
    assign bus.ovr = str_reg[7:4];
    assign bus.shutdown = shutdown_reg;
    assign bus.lsac = as0_reg[AS0_LSAC +: 2];
    assign bus.lsbd = as0_reg[AS0_LSBD +: 2];
    assign output_level = bus.level;
    assign output_enable = bus.drive;

    steer_stage u_stage (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bus(bus.stage)
    );

    sequence s_quiet;
        !(wr_en && paddr == OFS_AS0);
    endsequence

    a_lc2_trigger: assert property ( // [R1]
        @(posedge sys_clk) disable iff (!rst_n)
        logic_cell_out[1] && as1_reg[SRC_LC2] |=> shutdown_reg)
        else $error("logic cell source did not shut down");
    a_cmp2_ignored: assert property ( // [R2]
        @(posedge sys_clk) disable iff (!rst_n)
        (!shutdown_reg && !as1_reg[SRC_CMP2] && comparator_out[1]
            && (sources == 5'h0)) and s_quiet |=> !shutdown_reg)
        else $error("disabled comparator source shut down");
    a_cmp1_trigger: assert property ( // [R3]
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(comparator_out[0]) && as1_reg[SRC_CMP1] |=> shutdown_reg)
        else $error("comparator source did not shut down");
    a_timer_trigger: assert property ( // [R4]
        @(posedge sys_clk) disable iff (!rst_n)
        timer_postscale_out && as1_reg[SRC_TMR] |=> shutdown_reg [*1] ##1
            shutdown_reg || !timer_postscale_out)
        else $error("timer source did not hold shutdown");
    a_pin_trigger: assert property ( // [R5]
        @(posedge sys_clk) disable iff (!rst_n)
        mapped_input_pin_select && as1_reg[SRC_PIN] |=> shutdown_reg)
        else $error("input pin source did not shut down");
    a_auto_restart: assert property ( // [R16]
        @(posedge sys_clk) disable iff (!rst_n)
        (shutdown_reg && as0_reg[AS0_REN] && !request) and s_quiet
            |=> !shutdown_reg && events[IRQ_LEAVE]
            ##1 irq_stat_reg[IRQ_LEAVE])
        else $error("auto-restart did not release shutdown");
    a_reserved_input: assert property ( // [R13]
        @(posedge sys_clk) disable iff (!rst_n)
        dat_reg[3:1] == 3'h7 |=> !wave_reg)
        else $error("reserved input code passed a source");
    a_cmp_input: assert property ( // [R12]
        @(posedge sys_clk) disable iff (!rst_n)
        dat_reg == 4'h9 |=> wave_reg == $past(comparator_out[1]))
        else $error("comparator input was not selected");
    a_pwm_input: assert property ( // [R11]
        @(posedge sys_clk) disable iff (!rst_n)
        dat_reg == 4'h6 |=> wave_reg == $past(pwm_out[3]))
        else $error("pwm input was not selected");
    a_clock_reset: assert property (@(posedge sys_clk) // [R10]
        !rst_n |=> !gen_clock_select)
        else $error("clock select not cleared by reset");
endmodule
`default_nettype wire

// [include/waveform_steer_pkg.sv]
// Constants, field layout and types of the waveform steering block.
// Assumes a byte-addressed APB slave, one 32-bit word per register.
//
// What this block does
// R1: Enabled second logic cell output triggers shutdown; else ignored.
// R2: Enabled second comparator output triggers shutdown; else no effect.
// R3: Enabled first comparator output triggers shutdown; else ignored.
// R4: Enable at bit 1 lets timer postscaled output trigger shutdown.
// R5: Enable at bit 0 lets the mapped input pin trigger shutdown.
// R6: Steering enable set routes data waveform with polarity to that output.
// R7: Steering enable clear forces the output to its override bit.
// R8: Steering and override bits act only in mode 000 or 001.
// R9: In mode 001 steering enables apply only at the input rising edge.
// R10: Clock select set picks fast oscillator, clear picks system clock.
// R11: Input codes 0000 to 0111 pick clock, capture, PWM and oscillator.
// R12: Codes 1000, 1001 pick comparators; 1010 to 1101 pick logic cells.
// R13: Codes 1110 and 1111 connect no source to the input.
// R14: Mode 001 is synchronous steering; mode 000 is plain steering.
// R15: Outside shutdown, a set polarity bit inverts its output unless the override bit drives it; clear leaves it normal.
// R16: With auto-restart, shutdown clears once all enabled sources are low.
// R17: Shutdown request is the OR of all enabled sources.
// R18: Output levels are captured on generator clock ticks, glitch free.
package waveform_steer_pkg;
    localparam logic [7:0] OFS_CON0 = 8'h00;
    localparam logic [7:0] OFS_CON1 = 8'h04;
    localparam logic [7:0] OFS_DBR = 8'h08;
    localparam logic [7:0] OFS_DBF = 8'h0C;
    localparam logic [7:0] OFS_AS0 = 8'h10;
    localparam logic [7:0] OFS_AS1 = 8'h14;
    localparam logic [7:0] OFS_STR = 8'h18;
    localparam logic [7:0] OFS_CLK = 8'h1C;
    localparam logic [7:0] OFS_DAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h28;
    localparam logic [7:0] OFS_IRQ_EN = 8'h2C;
    localparam int CON0_EN = 7;
    localparam int CON0_LD = 6;
    localparam int CON1_IN = 5;
    localparam int AS0_SHUT = 7;
    localparam int AS0_REN = 6;
    localparam int AS0_LSBD = 4;
    localparam int AS0_LSAC = 2;
    localparam int SRC_LC2 = 4;
    localparam int SRC_CMP2 = 3;
    localparam int SRC_CMP1 = 2;
    localparam int SRC_TMR = 1;
    localparam int SRC_PIN = 0;
    localparam int IRQ_ENTER = 0;
    localparam int IRQ_LEAVE = 1;
    localparam logic [7:0] CON0_MASK = 8'h87;
    localparam logic [7:0] POL_MASK = 8'h0F;
    localparam logic [7:0] DB_MASK = 8'h3F;
    localparam logic [7:0] AS0_MASK = 8'h7C;
    localparam logic [7:0] AS1_MASK = 8'h1F;
    localparam logic [7:0] CLK_MASK = 8'h01;
    localparam logic [7:0] DAT_MASK = 8'h0F;
    localparam logic [7:0] IRQ_MASK = 8'h03;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] AS0_RESET = 8'h14;
    localparam logic [2:0] MODE_STEER = 3'h0;
    localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
    localparam logic [1:0] SHUT_HIGH = 2'h3;
    localparam logic [1:0] SHUT_LOW = 2'h2;
    localparam logic [1:0] SHUT_FLOAT = 2'h1;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SHUT = 3'b010,
        ST_HOLD = 3'b100
    } out_state_t;
endpackage

// [include/steer_if.sv]
// Carrier between the register side and the output stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface steer_if;
    logic wave;
    logic wave_rise;
    logic gen_tick;
    logic enable;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [3:0] str;
    logic [3:0] ovr;
    logic shutdown;
    logic [1:0] lsac;
    logic [1:0] lsbd;
    logic [3:0] level;
    logic [3:0] drive;
    logic [3:0] live_str;
    modport ctrl (output wave, wave_rise, gen_tick, enable, mode, pol, str,
        ovr, shutdown, lsac, lsbd, input level, drive, live_str);
    modport stage (input wave, wave_rise, gen_tick, enable, mode, pol, str,
        ovr, shutdown, lsac, lsbd, output level, drive, live_str);
endinterface
`default_nettype wire

// [src/steer_stage.sv]
// Output stage: steering, override, polarity and shutdown levels.
// Assumes configuration and the sampled input waveform come over steer_if.
`timescale 1ns/100ps
`default_nettype none
module steer_stage
    import waveform_steer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    steer_if.stage bus
);
    out_state_t state_reg, state_next;
    logic [3:0] live_str_reg;
    logic [3:0] level_reg, level_next;
    logic [3:0] drive_reg, drive_next;

    // Level placed on a pin while shutdown holds; drive low means floating.
    function automatic logic [1:0] shut_level(input logic [1:0] sel,
        input logic pol);
        case (sel)
            SHUT_HIGH: shut_level = 2'h3;
            SHUT_LOW: shut_level = 2'h2;
            SHUT_FLOAT: shut_level = 2'h0;
            default: shut_level = {1'b1, pol};
        endcase
    endfunction

    // Shutdown stays in force until the first input rising edge after release.
    always_comb begin
        case (state_reg)
            ST_RUN: state_next = bus.shutdown ? ST_SHUT : ST_RUN;
            ST_SHUT: state_next = bus.shutdown ? ST_SHUT : ST_HOLD;
            ST_HOLD: begin
                if (bus.shutdown) begin
                    state_next = ST_SHUT;
                end else begin
                    state_next = bus.wave_rise ? ST_RUN : ST_HOLD;
                end
            end
            default: state_next = ST_SHUT;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Synchronous steering loads the enables on the input rising edge only.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            live_str_reg <= 4'h0;
        end else if (bus.mode != MODE_SYNC_STEER
                || bus.wave_rise) begin // [R9] [R14]
            live_str_reg <= bus.str;
        end
    end

    // Per output: shutdown, disabled, steering modes, other modes.
    always_comb begin
        level_next = 4'h0;
        drive_next = 4'hF;
        for (int i = 0; i < 4; i++) begin
            if (state_reg != ST_RUN) begin
                {drive_next[i], level_next[i]} =
                    shut_level(i[0] ? bus.lsbd : bus.lsac, bus.pol[i]);
            end else if (!bus.enable) begin
                level_next[i] = bus.pol[i];
            end else if (bus.mode[2:1] == 2'h0) begin // [R8] [R14]
                level_next[i] = live_str_reg[i] ?
                    (bus.wave ^ bus.pol[i]) : bus.ovr[i]; // [R6] [R7] [R15]
            end else begin
                level_next[i] = bus.wave ^ bus.pol[i]; // [R15]
            end
        end
    end

    // Pins only change on a generator clock tick.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_reg <= 4'h0;
            drive_reg <= 4'h0;
        end else if (bus.gen_tick) begin // [R18]
            level_reg <= level_next;
            drive_reg <= drive_next;
        end
    end

    assign bus.level = level_reg;
    assign bus.drive = drive_reg;
    assign bus.live_str = live_str_reg;

    sequence s_steer_a;
        state_reg == ST_RUN && bus.enable && bus.mode[2:1] == 2'h0
            && bus.gen_tick;
    endsequence

    a_sync_buffered: assert property ( // [R9]
        @(posedge sys_clk) disable iff (!rst_n)
        bus.mode == MODE_SYNC_STEER && !bus.wave_rise
            |=> $stable(live_str_reg))
        else $error("steering enables changed without an input edge");
    a_override_force: assert property ( // [R7]
        @(posedge sys_clk) disable iff (!rst_n)
        s_steer_a and !live_str_reg[0] |=> bus.level[0] == $past(bus.ovr[0]))
        else $error("output a did not take its override level");
    a_steer_wave: assert property ( // [R6]
        @(posedge sys_clk) disable iff (!rst_n)
        s_steer_a and live_str_reg[1]
            |=> bus.level[1] == ($past(bus.wave) ^ $past(bus.pol[1])))
        else $error("output b did not follow the data waveform");
    a_mode_ignores: assert property ( // [R8]
        @(posedge sys_clk) disable iff (!rst_n)
        state_reg == ST_RUN && bus.enable && bus.mode[2:1] != 2'h0
            && bus.gen_tick
            |=> bus.level == ({4{$past(bus.wave)}} ^ $past(bus.pol)))
        else $error("steering bits acted outside the steering modes");
endmodule
`default_nettype wire

// [bench/bridge_driver_model.sv]
// Behavioural model of the bridge driver stage fed by outputs A to D.
// Assumes each gate driver input carries a weak pull-down resistor.
`timescale 1ns/100ps
`default_nettype none
module bridge_driver_model (
    input wire logic [3:0] level,
    input wire logic [3:0] drive_en,
    output logic [3:0] pin
);
    // A released line falls to its pull-down, so it never keeps old data.
    assign pin = level & drive_en;
endmodule
`default_nettype wire

// [bench/waveform_steer_bench.sv]
// Self-checking bench of the waveform steering block over APB.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module waveform_steer_bench;
    import waveform_steer_pkg::*;
    logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic err, gcs, irq, osc;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, lvl, oen, pins;
    logic [13:0] src;
    logic [4:0] sdv;
    int mismatches, checks_done;

    waveform_steer dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_derived_input(src[0]), .ccp_out(src[2:1]),
        .pwm_out(src[6:3]), .nco_out(src[7]),
        .comparator_out(src[9:8] | sdv[3:2]),
        .logic_cell_out(src[13:10] | {2'b00, sdv[4], 1'b0}),
        .timer_postscale_out(sdv[1]), .mapped_input_pin_select(sdv[0]),
        .internal_fast_oscillator(osc), .gen_clock_select(gcs),
        .output_level(lvl), .output_enable(oen), .irq(irq));
    bridge_driver_model drv (.level(lvl), .drive_en(oen), .pin(pins));

    // Free-running 100 MHz system clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // Input sample plus one generator tick, with margin.
    task automatic hold4;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence of register calls and expected values.
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        src = 14'h0;
        sdv = 5'h0;
        osc = 1'b0;
        mismatches = 0;
        checks_done = 0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rdchk("steering", OFS_STR, 32'h0);
        rdchk("clock sel", OFS_CLK, 32'h0);
        rdchk("input sel", OFS_DAT, 32'h0);
        rdchk("sd ctrl", OFS_AS0, {24'h0, AS0_RESET});
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        // Only the chosen source is high; reserved codes see all high.
        for (int c = 0; c < 16; c++) begin
            wr(OFS_DAT, 32'(c));
            src <= (c < 14) ? 14'h1 << c : 14'h3FFF;
            hold4;
            rdchk("in bit", OFS_CON1,
                (c < 14) ? 32'h20 : 32'h0);
        end
        wr(OFS_DAT, 32'h0);
        src <= 14'h1;
        wr(OFS_CON1, 32'h1);
        wr(OFS_STR, 32'hA3);
        wr(OFS_CON0, 32'h80);
        hold4;
        chk("steer pins", 32'hA, pins);
        wr(OFS_CON0, 32'h82);
        hold4;
        chk("bridge pins", 32'hE, pins);
        // Synchronous steering waits for a rising input edge.
        wr(OFS_CON1, 32'hF);
        src <= 14'h0;
        wr(OFS_CON0, 32'h80);
        wr(OFS_STR, 32'h0);
        wr(OFS_CON0, 32'h81);
        wr(OFS_STR, 32'hF);
        hold4;
        chk("held pins", 32'h0, pins);
        src <= 14'h1;
        hold4;
        src <= 14'h0;
        hold4;
        chk("synced pins", 32'hF, pins);
        // Clock select: outputs move only on oscillator ticks.
        wr(OFS_CLK, 32'h1);
        chk("gen clk", 32'h1, {31'h0, gcs});
        src <= 14'h1;
        hold4;
        chk("frozen pins", 32'hF, pins);
        osc <= 1'b1;
        @(posedge sys_clk);
        osc <= 1'b0;
        hold4;
        chk("ticked pins", 32'h0, pins);
        wr(OFS_CLK, 32'h0);
        src <= 14'h0;
        wr(OFS_CON0, 32'h80);
        // Each source masked, then enabled, with auto-restart on.
        wr(OFS_AS0, 32'h54);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_AS1, 32'h1F ^ (32'h1 << i));
            sdv <= 5'(1 << i);
            hold4;
            rdchk("masked src", OFS_AS0, 32'h54);
            sdv <= 5'h0;
            wr(OFS_AS1, 32'h1 << i);
            sdv <= 5'(1 << i);
            hold4;
            rdchk("enabled src", OFS_AS0,
                32'hD4);
            chk("float", 32'h0, oen);
            sdv <= 5'h0;
            hold4;
            rdchk("restart", OFS_AS0, 32'h54);
        end
        // Interrupt masked, enabled, then cleared.
        rdchk("irq stat", OFS_IRQ_STAT, 32'h3);
        chk("masked irq", 32'h0, {31'h0, irq});
        wr(OFS_IRQ_EN, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(OFS_IRQ_CLR, 32'h3);
        chk("irq off", 32'h0, {31'h0, irq});
        rdchk("irq clr", OFS_IRQ_STAT, 32'h0);
        report_and_stop;
    end

    // Watchdog against a hung transfer.
    initial begin
        #100us;
        mismatches++;
        report_and_stop;
    end
endmodule
`default_nettype wire
